// ---- pkg/srs_regs.svh ----
// Register offsets, field positions, flag bits, op codes and cycle counts of the exec slice
`ifndef SRS_REGS_SVH
`define SRS_REGS_SVH

// Register offsets (byte addresses, one word each)
`define SRS_REG_CMD        8'h00
`define SRS_REG_LIT        8'h04
`define SRS_REG_FLAGS      8'h08
`define SRS_REG_STATUS     8'h0C
`define SRS_REG_CTRL       8'h10
`define SRS_REG_TBLPAGE    8'h14
`define SRS_REG_RETPC      8'h18
`define SRS_REG_FADDR      8'h1C
`define SRS_REG_FDATA      8'h20
// Working register window: 0x40 to 0x7C, selected by address bits 7:6
`define SRS_WIN_SEL        2'h1

// Command word fields
`define SRS_CMD_OP_LSB     0
`define SRS_CMD_DST_LSB    5
`define SRS_CMD_SRC_LSB    9
`define SRS_CMD_BASE_LSB   13
`define SRS_CMD_FSEL_BIT   17
`define SRS_CMD_WSEL_BIT   18
`define SRS_CMD_LSEL_BIT   19

// Status, control bits
`define SRS_STAT_BUSY_BIT  0
`define SRS_STAT_ARM_BIT   1
`define SRS_STAT_REP_LSB   16
`define SRS_CTRL_SHORT_BIT 0

// Flag bit positions and update masks
`define SRS_FLG_C          0
`define SRS_FLG_Z          1
`define SRS_FLG_OVF        2
`define SRS_FLG_N          3
`define SRS_FLG_DIGIT      4
`define SRS_MSK_NONE       5'h00
`define SRS_MSK_NZ         5'h0A
`define SRS_MSK_CNZ        5'h0B
`define SRS_MSK_ALL        5'h1F

// Operation codes
`define SRS_OP_REPEAT_LIT  5'h00
`define SRS_OP_REPEAT_REG  5'h01
`define SRS_OP_RET_LIT     5'h02
`define SRS_OP_ROTL_CARRY  5'h03
`define SRS_OP_ROTL_PLAIN  5'h04
`define SRS_OP_ROTR_CARRY  5'h05
`define SRS_OP_ROTR_PLAIN  5'h06
`define SRS_OP_SIGN_EXT    5'h07
`define SRS_OP_SHIFT_LEFT  5'h08
`define SRS_OP_SUB_BORROW  5'h09
`define SRS_OP_RSUB_BORROW 5'h0A
`define SRS_OP_TABLE_HIGH  5'h0B

// Cycle counts
`define SRS_CYC_ONE        2'h1
`define SRS_CYC_TABLE      2'h2
`define SRS_CYC_RET        2'h3
`define SRS_CYC_RET_SHORT  2'h2

// Reset values and fixed indices
`define SRS_FLAGS_RST      5'h00
`define SRS_WORK_REGS      16
`define SRS_DEFAULT_WORK   4'h0

`endif

// ---- pkg/srs_pkg.sv ----
// Types shared by the shift, rotate and subtract execution slice
`default_nettype none
package srs_pkg;
	typedef logic [4:0]  srs_op_t;    // Operation code
	typedef logic [15:0] srs_word_t;  // Data word
	typedef logic [4:0]  srs_flags_t; // Status flags
	typedef enum {srs_idle, srs_run} srs_state_e; // Sequencer states
endpackage
`default_nettype wire

// ---- rtl/srs_regfile.sv ----
// Working registers and data-memory file registers in one array
`timescale 1ns/1ps
`default_nettype none
module srs_regfile #(
	parameter int WORDS = 272,
	parameter int AW    = 9
) (
	// Clock and reset
	input  wire logic               clock,
	input  wire logic               reset,
	// Read ports
	input  wire logic [AW-1:0]      ra_idx,
	input  wire logic [AW-1:0]      rb_idx,
	input  wire logic [AW-1:0]      rc_idx,
	output srs_pkg::srs_word_t      ra,
	output srs_pkg::srs_word_t      rb,
	output srs_pkg::srs_word_t      rc,
	// Write port
	input  wire logic               we,
	input  wire logic [AW-1:0]      widx,
	input  wire srs_pkg::srs_word_t wdata
);
	// Refuse an array that the index cannot cover
	if (WORDS < 1 || WORDS > (1 << AW)) begin : g_chk
		$error("srs_regfile: WORDS does not fit AW");
	end

	srs_pkg::srs_word_t mem [WORDS]; // Storage, work registers first

	// Asynchronous read ports
	assign ra = mem[ra_idx];
	assign rb = mem[rb_idx];
	assign rc = mem[rc_idx];

	////////////////////////////////////////////////////////////////////////////////
	// Clear on reset, single write port otherwise
	always_ff @(posedge clock) begin
		if (reset) begin
			for (int i = 0; i < WORDS; i++) begin
				mem[i] <= 16'h0000;
			end
		end else if (we) begin
			mem[widx] <= wdata;
		end
	end
endmodule
`default_nettype wire

// ---- rtl/srs_alu.sv ----
// Rotate, shift, sign-extend and subtract-with-borrow datapath
`timescale 1ns/1ps
`include "srs_regs.svh"
`default_nettype none
module srs_alu (
	// Operation and operands
	input  wire srs_pkg::srs_op_t   op,
	input  wire srs_pkg::srs_word_t a,
	input  wire srs_pkg::srs_word_t b,
	input  wire logic               cin,
	// Result and flags
	output srs_pkg::srs_word_t      res,
	output srs_pkg::srs_flags_t     flg,
	output srs_pkg::srs_flags_t     msk
);
	wire        is_rev = (op == `SRS_OP_RSUB_BORROW);  // Reverse operand order
	wire [15:0] minu   = is_rev ? b : a;               // Minuend
	wire [15:0] subt   = is_rev ? a : b;               // Subtrahend
	// Add the complement: carry out is the inverted borrow
	wire [16:0] diff   = {1'b0, minu} + {1'b0, ~subt} + {16'h0000, cin};
	wire [4:0]  nib    = {1'b0, minu[3:0]} + {1'b0, ~subt[3:0]} + {4'h0, cin};
	wire        ov     = (minu[15] ^ subt[15]) & (minu[15] ^ diff[15]);
	logic       c;                                     // Carry result

	////////////////////////////////////////////////////////////////////////////////
	// Result, carry and update mask per operation
	always_comb begin
		res = 16'h0000;
		c   = cin;
		msk = `SRS_MSK_NONE;
		case (op)
			`SRS_OP_ROTL_CARRY: begin
				res = {a[14:0], cin};
				c   = a[15];
				msk = `SRS_MSK_CNZ;
			end
			`SRS_OP_ROTL_PLAIN: begin
				res = {a[14:0], a[15]};
				msk = `SRS_MSK_NZ;
			end
			`SRS_OP_ROTR_CARRY: begin
				res = {cin, a[15:1]};
				c   = a[0];
				msk = `SRS_MSK_CNZ;
			end
			`SRS_OP_ROTR_PLAIN: begin
				res = {a[0], a[15:1]};
				msk = `SRS_MSK_NZ;
			end
			`SRS_OP_SIGN_EXT: begin
				res = {{8{a[7]}}, a[7:0]};
				c   = ~a[7];
				msk = `SRS_MSK_CNZ;
			end
			`SRS_OP_SHIFT_LEFT: begin
				res = a << b[4:0];
				msk = `SRS_MSK_NZ;
			end
			`SRS_OP_SUB_BORROW, `SRS_OP_RSUB_BORROW: begin
				res = diff[15:0];
				c   = diff[16];
				msk = `SRS_MSK_ALL;
			end
			default: begin
				msk = `SRS_MSK_NONE;
			end
		endcase
	end

	// Flags packed in register order
	assign flg = {nib[4], res[15], ov, (res == 16'h0000), c};
endmodule
`default_nettype wire

// ---- rtl/srs_exec.sv ----
// Execution sequencer for repeat, literal return, table read and the datapath operations
//
// Contract
// - Literal repeat runs next op literal+1 times
// - Register repeat runs next op register+1 times
// - Literal return loads register, three or two cycles
// - Rotate left through carry, update C N Z
// - Rotate left plain, update N Z only
// - Rotate right through carry, update C N Z
// - Rotate right plain, carry kept, N Z
// - Sign extend low byte, update C N Z
// - Shift left by register amount, N Z
// - Shift left by five-bit literal, N Z
// - Operand minus subtrahend minus inverted carry
// - Literal minus base minus inverted carry
// - Table read high byte, two cycles, flags kept
`timescale 1ns/1ps
`include "srs_regs.svh"
`default_nettype none
module srs_exec #(
	parameter int FILE_WORDS = 256
) (
	// Clock and reset
	input  wire logic          clock,
	input  wire logic          reset,
	// Register port
	input  wire logic [7:0]    bus_addr,
	input  wire logic [31:0]   bus_wdata,
	input  wire logic          bus_wr,
	input  wire logic          bus_rd,
	output logic      [31:0]   bus_rdata_q,
	// Program memory table port
	output logic      [23:0]   prog_addr_q,
	output logic               prog_rd_q,
	input  wire logic [23:0]   prog_data,
	// Core status
	output logic               busy_q,
	output logic               ret_q,
	output logic      [23:0]   ret_pc_q,
	output srs_pkg::srs_flags_t flags_q
);
	localparam int FAW = $clog2(FILE_WORDS);
	localparam int AW  = $clog2(`SRS_WORK_REGS + FILE_WORDS);

	// Refuse a file size that the index arithmetic cannot serve
	if (FILE_WORDS < 2 || FILE_WORDS > 8192 || (1 << FAW) != FILE_WORDS) begin : g_chk
		$error("srs_exec: FILE_WORDS must be a power of two from 2 to 8192");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Decode helpers
	function automatic logic [3:0] f_reg(input logic [31:0] w, input int lsb);
		f_reg = 4'(w >> lsb);
	endfunction

	function automatic logic [AW-1:0] f_widx(input logic [3:0] n);
		f_widx = AW'(n);
	endfunction

	function automatic logic [AW-1:0] f_fidx(input logic [FAW-1:0] f);
		f_fidx = AW'(f) + AW'(`SRS_WORK_REGS);
	endfunction

	function automatic logic [1:0] f_len(input srs_pkg::srs_op_t o, input logic s);
		if (o == `SRS_OP_TABLE_HIGH) f_len = `SRS_CYC_TABLE;
		else if (o == `SRS_OP_RET_LIT) f_len = s ? `SRS_CYC_RET_SHORT : `SRS_CYC_RET;
		else f_len = `SRS_CYC_ONE;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// State
	srs_pkg::srs_state_e state_q, state_d;  // Sequencer state
	logic [19:0]         cmd_q;             // Command being executed
	logic [13:0]         lit_q;             // Literal / file address
	logic [1:0]          cyc_q, len_q;      // Cycle in op, op length
	logic [15:0]         iter_q;            // Executions still to come
	logic [15:0]         rep_left_q;        // Armed repeat count
	logic                rep_armed_q;       // Repeat waits for next op
	logic                short_q;           // Short return timing
	logic [7:0]          page_q;            // Table page
	logic [FAW-1:0]      faddr_q;           // File access pointer

	srs_pkg::srs_word_t  ra, rb, rc, alu_res;
	srs_pkg::srs_flags_t alu_flg, alu_msk;

	////////////////////////////////////////////////////////////////////////////////
	// Command decode: bus word while issuing, held command after
	wire        idle     = (state_q == srs_pkg::srs_idle);
	wire        run      = (state_q == srs_pkg::srs_run);
	wire        wr_ok    = bus_wr & idle;                    // Writes refused when busy
	wire        is_cmd   = (bus_addr == `SRS_REG_CMD);
	wire        issue    = wr_ok & is_cmd & (5'(bus_wdata) <= `SRS_OP_TABLE_HIGH);
	wire [31:0] live     = issue ? bus_wdata : {12'h000, cmd_q};
	wire [4:0]  op       = 5'(live >> `SRS_CMD_OP_LSB);
	wire [3:0]  dst      = f_reg(live, `SRS_CMD_DST_LSB);
	wire [3:0]  src      = f_reg(live, `SRS_CMD_SRC_LSB);
	wire [3:0]  base     = f_reg(live, `SRS_CMD_BASE_LSB);
	wire        fsel     = live[`SRS_CMD_FSEL_BIT];         // Operand is a file register
	wire        wsel     = live[`SRS_CMD_WSEL_BIT];         // Result to default work reg
	wire        lsel     = live[`SRS_CMD_LSEL_BIT];         // Second operand is literal
	wire        is_sub   = (op == `SRS_OP_SUB_BORROW) | (op == `SRS_OP_RSUB_BORROW);
	wire        use_base = is_sub | (op == `SRS_OP_SHIFT_LEFT);
	wire        is_rep   = (op == `SRS_OP_REPEAT_LIT) | (op == `SRS_OP_REPEAT_REG);

	// Operand selection
	wire [AW-1:0] file_idx = f_fidx(lit_q[FAW-1:0]);
	wire [AW-1:0] ra_idx   = fsel ? file_idx : f_widx(use_base ? base : src);
	wire [AW-1:0] rb_idx   = fsel ? f_widx(`SRS_DEFAULT_WORK) : f_widx(src);
	wire [15:0]   b_val    = lsel ? {11'h000, lit_q[4:0]} : rb;

	// Completion and repetition
	wire done    = run & (cyc_q == 2'(len_q - 2'h1));
	wire restart = done & (iter_q != 16'h0000);

	// Result write-back
	wire [AW-1:0] dest_idx = (fsel & ~wsel) ? file_idx :
		f_widx(wsel ? `SRS_DEFAULT_WORK : dst);
	wire [15:0]   wr_val   = (op == `SRS_OP_RET_LIT) ? {6'h00, lit_q[9:0]} :
		(op == `SRS_OP_TABLE_HIGH) ? {8'h00, prog_data[23:16]} : alu_res;
	wire          ex_we    = done & ~is_rep;

	// Register port decode
	wire          in_win   = (bus_addr[7:6] == `SRS_WIN_SEL) & (bus_addr[1:0] == 2'h0);
	wire          is_fdat  = (bus_addr == `SRS_REG_FDATA);
	wire [AW-1:0] rc_idx   = in_win ? f_widx(bus_addr[5:2]) : f_fidx(faddr_q);
	wire          bus_we   = wr_ok & (in_win | is_fdat);
	wire [31:0]   status   = {rep_left_q, 14'h0000, rep_armed_q, busy_q};
	wire [31:0]   rd_mux   =
		is_cmd                          ? {12'h000, cmd_q} :
		(bus_addr == `SRS_REG_LIT)     ? {18'h00000, lit_q} :
		(bus_addr == `SRS_REG_FLAGS)   ? {27'h0000000, flags_q} :
		(bus_addr == `SRS_REG_STATUS)  ? status :
		(bus_addr == `SRS_REG_CTRL)    ? {31'h00000000, short_q} :
		(bus_addr == `SRS_REG_TBLPAGE) ? {24'h000000, page_q} :
		(bus_addr == `SRS_REG_RETPC)   ? {8'h00, ret_pc_q} :
		(bus_addr == `SRS_REG_FADDR)   ? 32'(faddr_q) :
		(in_win | is_fdat)             ? {16'h0000, rc} : 32'h00000000;

	////////////////////////////////////////////////////////////////////////////////
	// Datapath and storage
	srs_alu u_alu (
		.op  (op),
		.a   (ra),
		.b   (b_val),
		.cin (flags_q[`SRS_FLG_C]),
		.res (alu_res),
		.flg (alu_flg),
		.msk (alu_msk)
	);

	srs_regfile #(
		.WORDS (`SRS_WORK_REGS + FILE_WORDS),
		.AW    (AW)
	) u_rf (
		.clock  (clock),
		.reset  (reset),
		.ra_idx (ra_idx),
		.rb_idx (rb_idx),
		.rc_idx (rc_idx),
		.ra     (ra),
		.rb     (rb),
		.rc     (rc),
		.we     (ex_we | bus_we),
		.widx   (ex_we ? dest_idx : rc_idx),
		.wdata  (ex_we ? wr_val : bus_wdata[15:0])
	);

	////////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		state_d = state_q;
		case (state_q)
			srs_pkg::srs_idle: if (issue) state_d = srs_pkg::srs_run;
			srs_pkg::srs_run:  if (done & ~restart) state_d = srs_pkg::srs_idle;
			default:           state_d = srs_pkg::srs_idle;
		endcase
	end

	// Sequencer, cycle counter and repeat iterations
	always_ff @(posedge clock) begin
		if (reset) begin
			state_q <= srs_pkg::srs_idle;
			cmd_q   <= 20'h00000;
			cyc_q   <= 2'h0;
			len_q   <= `SRS_CYC_ONE;
			iter_q  <= 16'h0000;
			busy_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			busy_q  <= (state_d == srs_pkg::srs_run);
			if (issue) begin
				cmd_q  <= bus_wdata[19:0];
				cyc_q  <= 2'h0;
				len_q  <= f_len(op, short_q);
				iter_q <= rep_armed_q ? rep_left_q : 16'h0000;
			end else if (restart) begin
				cyc_q  <= 2'h0;
				iter_q <= 16'(iter_q - 16'h0001);
			end else if (run) begin
				cyc_q  <= 2'(cyc_q + 2'h1);
			end
		end
	end

	// Repeat arming; the next issued op consumes it
	always_ff @(posedge clock) begin
		if (reset) begin
			rep_armed_q <= 1'b0;
			rep_left_q  <= 16'h0000;
		end else if (done & (op == `SRS_OP_REPEAT_LIT)) begin
			rep_armed_q <= 1'b1;
			rep_left_q  <= {2'b00, lit_q};
		end else if (done & (op == `SRS_OP_REPEAT_REG)) begin
			rep_armed_q <= 1'b1;
			rep_left_q  <= ra;
		end else if (issue) begin
			rep_armed_q <= 1'b0;
		end
	end

	// Flags: masked update on completion, software write when idle
	always_ff @(posedge clock) begin
		if (reset) begin
			flags_q <= `SRS_FLAGS_RST;
		end else if (done) begin
			flags_q <= (flags_q & ~alu_msk) | (alu_flg & alu_msk);
		end else if (wr_ok & (bus_addr == `SRS_REG_FLAGS)) begin
			flags_q <= bus_wdata[4:0];
		end
	end

	// Program memory read request and return pulse
	always_ff @(posedge clock) begin
		if (reset) begin
			prog_rd_q   <= 1'b0;
			prog_addr_q <= 24'h000000;
			ret_q       <= 1'b0;
		end else begin
			prog_rd_q <= (issue | restart) & (op == `SRS_OP_TABLE_HIGH);
			if ((issue | restart) & (op == `SRS_OP_TABLE_HIGH)) begin
				prog_addr_q <= {page_q, rb};
			end
			ret_q <= done & (op == `SRS_OP_RET_LIT);
		end
	end

	// Software registers
	always_ff @(posedge clock) begin
		if (reset) begin
			lit_q    <= 14'h0000;
			short_q  <= 1'b0;
			page_q   <= 8'h00;
			ret_pc_q <= 24'h000000;
			faddr_q  <= '0;
		end else if (wr_ok) begin
			if (bus_addr == `SRS_REG_LIT) lit_q <= bus_wdata[13:0];
			if (bus_addr == `SRS_REG_CTRL) short_q <= bus_wdata[`SRS_CTRL_SHORT_BIT];
			if (bus_addr == `SRS_REG_TBLPAGE) page_q <= bus_wdata[7:0];
			if (bus_addr == `SRS_REG_RETPC) ret_pc_q <= bus_wdata[23:0];
			if (bus_addr == `SRS_REG_FADDR) faddr_q <= bus_wdata[FAW-1:0];
		end
	end

	// Read data, one cycle after the strobe, zero otherwise
	always_ff @(posedge clock) begin
		if (reset) bus_rdata_q <= 32'h00000000;
		else bus_rdata_q <= bus_rd ? rd_mux : 32'h00000000;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking @(posedge clock); endclocking
	default disable iff (reset);

	wire [16:0] need  = {1'b0, (is_sub & (op == `SRS_OP_RSUB_BORROW)) ? ra : b_val}
		+ {16'h0000, ~flags_q[`SRS_FLG_C]};
	wire [15:0] minu  = (op == `SRS_OP_RSUB_BORROW) ? b_val : ra;

	rep_lit_a: assert property (
		done && op == `SRS_OP_REPEAT_LIT |=> rep_armed_q && rep_left_q == {2'b00, $past(lit_q)}
		&& $stable(flags_q)) else $error("literal repeat not armed with its count");
	rep_run_a: assert property (
		issue && rep_armed_q && rep_left_q == 16'h0001 && op == `SRS_OP_ROTL_PLAIN
		|=> busy_q [*2] ##1 !busy_q) else $error("repeated op did not run twice");
	rep_reg_a: assert property (
		done && op == `SRS_OP_REPEAT_REG |=> rep_left_q == $past(ra) && $stable(flags_q))
		else $error("register repeat count wrong");
	ret_long_a: assert property (
		issue && op == `SRS_OP_RET_LIT && !short_q && !rep_armed_q
		|=> !ret_q [*3] ##1 (ret_q && $stable(flags_q))) else $error("long return timing");
	ret_short_a: assert property (
		issue && op == `SRS_OP_RET_LIT && short_q && !rep_armed_q
		|=> !ret_q [*2] ##1 ret_q) else $error("short return timing");
	rot_lc_a: assert property (
		done && op == `SRS_OP_ROTL_CARRY |-> alu_res == {ra[14:0], flags_q[`SRS_FLG_C]}
		##1 flags_q[`SRS_FLG_C] == $past(ra[15])) else $error("rotate left carry wrong");
	rot_lp_a: assert property (
		done && op == `SRS_OP_ROTL_PLAIN |=> $stable(flags_q[`SRS_FLG_C])
		&& flags_q[`SRS_FLG_N] == $past(ra[14])) else $error("rotate left plain wrong");
	rot_rc_a: assert property (
		done && op == `SRS_OP_ROTR_CARRY |=> flags_q[`SRS_FLG_C] == $past(ra[0])
		&& flags_q[`SRS_FLG_N] == $past(flags_q[`SRS_FLG_C])) else $error("rotate right carry");
	rot_rp_a: assert property (
		done && op == `SRS_OP_ROTR_PLAIN |=> $stable(flags_q[`SRS_FLG_C])
		&& flags_q[`SRS_FLG_N] == $past(ra[0])) else $error("rotate right plain wrong");
	sign_ext_a: assert property (
		done && op == `SRS_OP_SIGN_EXT |-> alu_res == {{8{ra[7]}}, ra[7:0]}
		##1 flags_q[`SRS_FLG_N] == $past(ra[7])) else $error("sign extend wrong");
	shl_var_a: assert property (
		done && op == `SRS_OP_SHIFT_LEFT && !lsel |-> alu_res == 16'(ra << rb[4:0])
		##1 $stable(flags_q[`SRS_FLG_C])) else $error("variable shift wrong");
	shl_lit_a: assert property (
		done && op == `SRS_OP_SHIFT_LEFT && lsel && !fsel |-> alu_res == 16'(ra << lit_q[4:0]))
		else $error("literal shift wrong");
	sub_brw_a: assert property (
		done && op == `SRS_OP_SUB_BORROW
		|-> alu_res == 16'(ra - b_val - {15'h0000, ~flags_q[`SRS_FLG_C]}))
		else $error("subtract with borrow wrong");
	rsub_lit_a: assert property (
		done && op == `SRS_OP_RSUB_BORROW && lsel
		|-> alu_res == 16'({11'h000, lit_q[4:0]} - ra - {15'h0000, ~flags_q[`SRS_FLG_C]}))
		else $error("reverse subtract wrong");
	tbl_high_a: assert property (
		issue && op == `SRS_OP_TABLE_HIGH && !rep_armed_q
		|=> prog_rd_q ##1 (done && !prog_rd_q) ##1 (!busy_q && $stable(flags_q)))
		else $error("table read timing");
	brw_flag_a: assert property (
		done && is_sub |=> flags_q[`SRS_FLG_C] == ($past({1'b0, minu}) >= $past(need)))
		else $error("carry is not inverted borrow");

	rep_cov: cover property (done && is_rep ##1 rep_armed_q ##[1:12] issue ##[1:8] restart);
	ret_cov: cover property (issue && op == `SRS_OP_RET_LIT && short_q);
	tbl_cov: cover property (prog_rd_q ##1 done);
	brw_cov: cover property (done && is_sub && !alu_flg[`SRS_FLG_C]);
endmodule
`default_nettype wire

// ---- dv/srs_exec_tb.sv ----
// Self-checking bench for the shift, rotate and subtract execution slice
`timescale 1ns/1ps
`default_nettype none
module testbench;
	////////////////////////////////////////////////////////////////////////////////
	// Signals
	logic                clock;       // Core clock
	logic                reset;       // Synchronous reset
	logic [7:0]          bus_addr;    // Register address
	logic [31:0]         bus_wdata;   // Write data
	logic                bus_wr;      // Write strobe
	logic                bus_rd;      // Read strobe
	logic [31:0]         bus_rdata_q; // Read data
	logic [23:0]         prog_addr_q; // Table address
	logic                prog_rd_q;   // Table request
	logic [23:0]         prog_data;   // Table word
	logic                busy_q;      // Op running
	logic                ret_q;       // Return pulse
	logic [23:0]         ret_pc_q;    // Return target
	srs_pkg::srs_flags_t flags_q;     // Status flags
	int                  mismatches;  // Failed compares
	int                  cmp_count;   // Compares made
	int                  nbusy;       // Busy cycles of the last op
	logic                ret_seen;    // Return pulse at the end of the op
	logic [31:0]         rd;          // Last read value
	localparam logic [31:0] LS = 32'h0008_0000; // Second operand from the literal

	////////////////////////////////////////////////////////////////////////////////
	// Design
	srs_exec i_srs_exec (
		.clock       (clock),
		.reset       (reset),
		.bus_addr    (bus_addr),
		.bus_wdata   (bus_wdata),
		.bus_wr      (bus_wr),
		.bus_rd      (bus_rd),
		.bus_rdata_q (bus_rdata_q),
		.prog_addr_q (prog_addr_q),
		.prog_rd_q   (prog_rd_q),
		.prog_data   (prog_data),
		.busy_q      (busy_q),
		.ret_q       (ret_q),
		.ret_pc_q    (ret_pc_q),
		.flags_q     (flags_q)
	);

	// Clock at 25 MHz
	always #20 clock = ~clock;

	// Program memory: top byte tied to the page so a wrong address shows; garbage when idle
	always @(posedge clock) begin
		prog_data <= prog_rd_q ? {prog_addr_q[23:16] ^ 8'h66, prog_addr_q[15:0]} : ~prog_data;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Tasks
	task automatic results();
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Compare one value
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// One-cycle register write
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		bus_addr  <= a;
		bus_wdata <= d;
		bus_wr    <= 1'b1;
		@(posedge clock);
		bus_wr <= 1'b0;
	endtask

	// One-cycle register read, data taken in the following cycle
	task automatic rdr(input logic [7:0] a);
		@(posedge clock);
		bus_addr <= a;
		bus_rd   <= 1'b1;
		@(posedge clock);
		bus_rd <= 1'b0;
		@(negedge clock);
		rd = bus_rdata_q;
	endtask

	// Count busy cycles after an issue, bounded
	task automatic idle();
		nbusy = 0;
		@(negedge clock);
		while (busy_q === 1'b1 && nbusy < 20) begin
			nbusy++;
			@(negedge clock);
		end
		ret_seen = ret_q;
		if (nbusy >= 20) begin
			mismatches++;
			$display("[FAIL] %0t op never finished", $time);
			results();
		end
	endtask

	// Datapath op: W1 source, W3 base, W2 destination
	task automatic op(input logic [4:0] code, input logic [31:0] extra, input logic [13:0] lit,
			input logic [4:0] fl, input logic [15:0] a, input logic [15:0] b,
			input logic [15:0] exp, input logic [4:0] ef);
		wr(8'h44, {16'h0000, a});
		wr(8'h4C, {16'h0000, b});
		wr(8'h04, {18'h00000, lit});
		wr(8'h08, {27'h0000000, fl});
		wr(8'h00, extra | 32'h0000_6240 | {27'h0000000, code});
		idle();
		chk(nbusy, 32'h1);
		rdr(8'h48);
		chk(rd, {16'h0000, exp});
		chk({27'h0000000, flags_q}, {27'h0000000, ef});
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Sequence
	initial begin
		clock      = 1'b0;
		reset      = 1'b1;
		bus_addr   = 8'h00;
		bus_wdata  = 32'h0000_0000;
		bus_wr     = 1'b0;
		bus_rd     = 1'b0;
		prog_data  = 24'h000000;
		mismatches = 0;
		cmp_count  = 0;
		repeat (6) @(posedge clock);
		reset <= 1'b0;
		// Cleared state after reset
		rdr(8'h08);
		chk(rd, 32'h0);
		rdr(8'h40);
		chk(rd, 32'h0);
		// Rotates, sign extension and shifts
		op(5'h03, 0, 0, 5'h00, 16'h8001, 0, 16'h0002, 5'h01);
		op(5'h03, 0, 0, 5'h01, 16'h4000, 0, 16'h8001, 5'h08);
		op(5'h04, 0, 0, 5'h01, 16'h8001, 0, 16'h0003, 5'h01);
		op(5'h05, 0, 0, 5'h00, 16'h0001, 0, 16'h0000, 5'h03);
		op(5'h06, 0, 0, 5'h05, 16'h0001, 0, 16'h8000, 5'h0D);
		op(5'h07, 0, 0, 5'h00, 16'h1280, 0, 16'hFF80, 5'h08);
		op(5'h07, 0, 0, 5'h08, 16'hFF05, 0, 16'h0005, 5'h01);
		op(5'h08, 0, 0, 5'h01, 16'h0004, 16'h0003, 16'h0030, 5'h01);
		op(5'h08, 0, 0, 5'h00, 16'h0010, 16'h0003, 16'h0000, 5'h02);
		op(5'h08, LS, 14'h000F, 5'h00, 16'h0001, 16'h0003, 16'h8000, 5'h08);
		// Subtracts with borrow, carry as inverted borrow
		op(5'h09, 0, 0, 5'h01, 16'h0003, 16'h0005, 16'h0002, 5'h11);
		op(5'h09, 0, 0, 5'h00, 16'h0005, 16'h0005, 16'hFFFF, 5'h08);
		op(5'h09, 0, 0, 5'h01, 16'h0001, 16'h8000, 16'h7FFF, 5'h05);
		op(5'h09, 0, 0, 5'h01, 16'h0003, 16'h0003, 16'h0000, 5'h13);
		op(5'h0A, 0, 0, 5'h01, 16'h0009, 16'h0004, 16'h0005, 5'h11);
		op(5'h0A, LS, 14'h0010, 5'h01, 0, 16'h0003, 16'h000D, 5'h01);
		op(5'h0A, LS, 14'h0010, 5'h00, 0, 16'h0011, 16'hFFFE, 5'h08);
		// Literal repeat: rotate W1 in place three times, flags kept by the repeat
		wr(8'h08, 32'h15);
		wr(8'h44, 32'h1);
		wr(8'h04, 32'h2);
		wr(8'h00, 32'h0);
		idle();
		chk({27'h0000000, flags_q}, 32'h15);
		rdr(8'h0C);
		chk(rd, 32'h0002_0002);
		wr(8'h00, 32'h224);
		idle();
		chk(nbusy, 32'h3);
		rdr(8'h44);
		chk(rd, 32'h8);
		// Register repeat: count from W4
		wr(8'h50, 32'h1);
		wr(8'h44, 32'h1);
		wr(8'h00, 32'h801);
		idle();
		chk({27'h0000000, flags_q}, 32'h15);
		rdr(8'h0C);
		chk(rd, 32'h0001_0002);
		wr(8'h00, 32'h224);
		idle();
		chk(nbusy, 32'h2);
		rdr(8'h44);
		chk(rd, 32'h4);
		// Literal return, long then short form, into W5
		wr(8'h18, 32'h123456);
		wr(8'h04, 32'h3FFF);
		for (int s = 0; s < 2; s++) begin
			wr(8'h10, s);
			wr(8'h54, 32'hFFFF);
			wr(8'h00, 32'hA2);
			idle();
			chk(nbusy, 3 - s);
			chk(ret_seen, 32'h1);
			chk(ret_pc_q, 32'h123456);
			chk({27'h0000000, flags_q}, 32'h15);
			rdr(8'h54);
			chk(rd, 32'h3FF);
		end
		// High table read through page and source register
		wr(8'h14, 32'hA5);
		wr(8'h44, 32'h1234);
		wr(8'h48, 32'hFFFF);
		wr(8'h00, 32'h24B);
		idle();
		chk(nbusy, 32'h2);
		chk({8'h00, prog_addr_q}, 32'h00A5_1234);
		chk({27'h0000000, flags_q}, 32'h15);
		rdr(8'h48);
		chk(rd, 32'hC3);
		// File register operand: result to the default work reg, then back to the file
		wr(8'h08, 32'h0);
		wr(8'h1C, 32'h5);
		wr(8'h20, 32'h8001);
		wr(8'h04, 32'h5);
		wr(8'h00, 32'h6_0003);
		idle();
		chk(nbusy, 32'h1);
		rdr(8'h40);
		chk(rd, 32'h2);
		wr(8'h00, 32'h2_0003);
		idle();
		chk(nbusy, 32'h1);
		rdr(8'h20);
		chk(rd, 32'h3);
		chk({27'h0000000, flags_q}, 32'h1);
		// Unknown op code is ignored, unmapped read gives zero
		wr(8'h00, 32'h0C);
		idle();
		chk(nbusy, 32'h0);
		rdr(8'h30);
		chk(rd, 32'h0);
		results();
	end
endmodule
`default_nettype wire
